/* File: design/stci_consts.svh */
`ifndef STCI_CONSTS_SVH
`define STCI_CONSTS_SVH

// sample and counter widths
`define STCI_SAMPLE_W    20
`define STCI_SEQ_W       8
`define STCI_BIT_W       6

// half-frame lengths in master clock periods
`define STCI_LEN_128     9'h080
`define STCI_LEN_192     9'h0C0
`define STCI_LEN_256     9'h100
`define STCI_LENSEL_128  2'h0
`define STCI_LENSEL_192  2'h1
`define STCI_LENSEL_256  2'h2

// serial timing
`define STCI_PH_SAMPLE   2'h1
`define STCI_SYNC_LAT    2'h2
`define STCI_BIT_SKIP    6'h00
`define STCI_BIT_FIRST   6'h01
`define STCI_BIT_LAST    6'h14
`define STCI_SIDE_LEFT   1'b0

// register byte offsets
`define STCI_OFS_CTRL    8'h00
`define STCI_OFS_STATUS  8'h04
`define STCI_OFS_ADC_L   8'h08
`define STCI_OFS_ADC_R   8'h0C
`define STCI_OFS_DAC_L   8'h10
`define STCI_OFS_DAC_R   8'h14

// control register fields
`define STCI_CTRL_EN     0
`define STCI_CTRL_LEN    2
`define STCI_CTRL_RST    4
`define STCI_CTRL_RESET  6'h00

// status register fields, four per channel
`define STCI_ST_ADC_RDY  0
`define STCI_ST_OVERRUN  1
`define STCI_ST_DAC_RDY  2
`define STCI_ST_UNDERRUN 3
`define STCI_ST_STRIDE   4
`define STCI_ST_SIDE     8

`endif

/* File: design/stci_pkg.sv */
`default_nettype none
package stci_pkg;
  `include "stci_consts.svh"

  // one audio channel: capture side, playback side and error flags
  typedef struct packed {
    logic [`STCI_SAMPLE_W-1:0] adc_sh;    // capture shift register
    logic                      adc_full;  // whole sample captured
    logic                      adc_rd;    // captured sample fetched
    logic [`STCI_SAMPLE_W-1:0] dac_sh;    // playback shift register
    logic                      dac_empty; // all bits sent
    logic                      dac_wr;    // new word loaded
    logic                      dac_bit;   // bit on the serial line
    logic                      overrun;   // sticky capture overflow
    logic                      underrun;  // sticky playback starvation
  } stci_chan_t;

  // software control word
  typedef struct packed {
    logic [1:0] crst; // per-channel reset, held while set
    logic [1:0] len;  // half-frame length select
    logic [1:0] en;   // per-channel host access enable
  } stci_ctrl_t;

  // whole state of the interface
  typedef struct packed {
    logic [`STCI_SEQ_W-1:0] seq;   // phase counter
    logic                   side;  // left/right select
    logic [1:0]             sync;  // serial input synchroniser
    stci_ctrl_t             ctrl;
    stci_chan_t [1:0]       chan;  // index 0 left, 1 right
    logic                   ack;
    logic [31:0]            rdata;
  } stci_state_t;
endpackage
`default_nettype wire

/* File: design/stci_top.sv */
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "stci_consts.svh"

module stci_top (
  input  wire logic        clk_i,       // system clock, 200 MHz
  input  wire logic        rst_i,       // synchronous reset, active high
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // codec pins
  output logic             mclk_o,      // master clock
  output logic             sclk_o,      // serial shift clock
  output logic             lrck_o,      // left/right select
  output logic             sdin_o,      // serial data to codec dac
  input  wire logic        sdout_i,     // serial data from codec adc
  // timing and status taps
  output logic      [5:0]  bit_idx_o,   // current serial bit
  output logic      [1:0]  bit_phase_o, // phase inside the bit
  output logic      [1:0]  adc_rdy_o,   // capture word ready per channel
  output logic      [1:0]  overrun_o,   // capture overflow per channel
  output logic      [1:0]  dac_rdy_o,   // playback slot ready per channel
  output logic      [1:0]  underrun_o   // playback starved per channel
);

  stci_pkg::stci_state_t q;  // registered state
  stci_pkg::stci_state_t d;  // next state

  // register map, byte offsets, upper bits read as zero:
  //   control  rw: host enable per lane, half-frame length code,
  //            per-lane channel reset held while the bit is set
  //   status   rw: ready, overflow, ready, starved per lane, then side;
  //            writing one to a sticky flag clears it, a set wins
  //   capture  ro: reading a lane is its fetch strobe
  //   playback rw: writing a lane is its load strobe, reading shows
  //            what is left in the playback shift register
  // a strobe only counts while the lane's host enable is set; the data
  // of a capture read is returned either way so software can peek
  // without disturbing the ready flag
  // everything sits in one state struct so reset and next state are in one place

  // value of a channel right after reset: playback register empty
  function automatic stci_pkg::stci_chan_t chan_reset();
    stci_pkg::stci_chan_t c;
    c           = '0;
    c.dac_empty = 1'b1;
    return c;
  endfunction

  // the length table is the only place that knows the legal
  // half-frame lengths of the codec
  // last counter value of a half frame; reserved select falls back to 128
  function automatic logic [7:0] half_end(input logic [1:0] sel);
    logic [8:0] len;
    len = `STCI_LEN_128;
    unique case (sel)
      `STCI_LENSEL_192: len = `STCI_LEN_192;
      `STCI_LENSEL_256: len = `STCI_LEN_256;
      default:          len = `STCI_LEN_128;
    endcase
    return 8'(len - 9'h001);
  endfunction

  // shared by the control write and the playback load
  // apply wishbone byte enables to a word
  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ready taps and status bits use the same term, so they never disagree
  // capture ready: full and not fetched yet
  function automatic logic adc_ready(input stci_pkg::stci_chan_t c);
    return c.adc_full && !c.adc_rd;
  endfunction

  // playback ready: empty and not loaded yet
  function automatic logic dac_ready(input stci_pkg::stci_chan_t c);
    return c.dac_empty && !c.dac_wr;
  endfunction

  // serial timing of one lane, four clocks to a bit:
  //   phase 1 of bit 0: playback leaves empty, starvation checked
  //   phase 1 of bits 1..20: next playback bit to the line flop
  //   phase 3 of bits 1..20: capture bit taken through the sync
  //   bit 20 marks capture full and playback empty again
  // the line flop puts each playback bit on the pin one phase after
  // the shift, so the codec sees it stable at its rising shift clock
  // one clock of a channel; both channels share this so they cannot drift
  function automatic stci_pkg::stci_chan_t chan_step(
    input stci_pkg::stci_chan_t c,
    input logic                 on,      // lane active
    input logic [5:0]           bitn,    // bit index
    input logic                 cap,     // capture phase seen through sync
    input logic                 snd,     // send phase
    input logic                 sd,      // synchronised serial input
    input logic                 en,      // host access enable
    input logic                 rd,      // fetch strobe
    input logic                 wr,      // load strobe
    input logic [31:0]          din,     // load data, bytes merged below
    input logic [3:0]           be,      // load byte enables
    input logic                 crst,    // channel reset
    input logic                 clr_ov,  // software clear of overflow
    input logic                 clr_un   // software clear of starvation
  );
    stci_pkg::stci_chan_t n;
    logic                 tcap;
    logic                 tsnd;
    logic                 load;
    logic [31:0]          merged;
    n      = c;
    tcap   = on && cap;
    tsnd   = on && snd;
    load   = en && wr;
    merged = byte_merge({12'h000, c.dac_sh}, din, be);

    // capture: bit zero is dropped, bits one to last shift in msb first
    if (tcap && bitn >= `STCI_BIT_FIRST && bitn < `STCI_BIT_LAST) begin
      n.adc_full = 1'b0;
      n.adc_sh   = {c.adc_sh[`STCI_SAMPLE_W-2:0], sd};
    end else if (tcap && bitn == `STCI_BIT_LAST) begin
      n.adc_full = 1'b1;
      n.adc_sh   = {c.adc_sh[`STCI_SAMPLE_W-2:0], sd};
    end

    // fetch flag holds while full; the first new bit clears it via full
    n.adc_rd = c.adc_full && ((en && rd) || c.adc_rd);

    // tested on the first real bit, one bit after the discarded one
    // overflow: first bit of a sample lands on an unread word; set wins
    if (tcap && bitn == `STCI_BIT_FIRST && adc_ready(c)) begin
      n.overrun = 1'b1;
    end else if (clr_ov) begin
      n.overrun = 1'b0;
    end

    // playback: a load wins over shifting, as the host owns the register
    if (load) begin
      n.dac_sh = merged[`STCI_SAMPLE_W-1:0];
    end else if (tsnd && bitn == `STCI_BIT_SKIP) begin
      n.dac_empty = 1'b0;
    end else if (tsnd && bitn >= `STCI_BIT_FIRST && bitn < `STCI_BIT_LAST) begin
      n.dac_bit = c.dac_sh[`STCI_SAMPLE_W-1];
      n.dac_sh  = {c.dac_sh[`STCI_SAMPLE_W-2:0], 1'b0};
    end else if (tsnd && bitn == `STCI_BIT_LAST) begin
      n.dac_bit   = c.dac_sh[`STCI_SAMPLE_W-1];
      n.dac_sh    = {c.dac_sh[`STCI_SAMPLE_W-2:0], 1'b0};
      n.dac_empty = 1'b1;
    end

    // load flag holds while empty; leaving empty clears it
    n.dac_wr = c.dac_empty && (load || c.dac_wr);

    // starvation: sending starts with no fresh word; set wins over clear
    if (tsnd && bitn == `STCI_BIT_SKIP && !c.dac_wr) begin
      n.underrun = 1'b1;
    end else if (clr_un) begin
      n.underrun = 1'b0;
    end

    // channel reset is a level; software holds it as long as it wants
    // channel reset beats everything
    if (crst) begin
      n = chan_reset();
    end
    return n;
  endfunction

  // bus decode terms
  logic        req;       // new request, not yet answered
  logic        wr_en;     // write taken this cycle
  logic        rd_en;     // read taken this cycle
  logic [7:0]  adr;       // word-aligned byte address
  logic [7:0]  ends;      // last counter value of this half frame
  logic        cap_ph;    // capture phase on the synchronised input
  logic        snd_ph;    // send phase
  logic [31:0] status;    // status word as read
  logic [31:0] ctrl_rd;   // control word as read
  logic [1:0]  lane_on;   // lane active per channel
  logic [1:0]  fetch;     // fetch strobe per channel
  logic [1:0]  load;      // load strobe per channel
  logic [1:0]  clr_ov;    // overflow clear per channel
  logic [1:0]  clr_un;    // starvation clear per channel
  logic [31:0] ctrl_new;  // control word after byte merge

  // next state
  always_comb begin
    d        = q;
    req      = wb_cyc_i && wb_stb_i && !q.ack;
    wr_en    = req && wb_we_i;
    rd_en    = req && !wb_we_i;
    adr      = {wb_adr_i[7:2], 2'b00};
    ends     = half_end(q.ctrl.len);
    // synchroniser adds two cycles, so look two phases later
    cap_ph   = q.seq[1:0] == 2'(`STCI_PH_SAMPLE + `STCI_SYNC_LAT);
    snd_ph   = q.seq[1:0] == `STCI_PH_SAMPLE;
    ctrl_rd  = {26'h0000000, q.ctrl};
    ctrl_new = byte_merge(ctrl_rd, wb_dat_i, wb_sel_i);
    lane_on  = {q.side != `STCI_SIDE_LEFT, q.side == `STCI_SIDE_LEFT};
    fetch    = {rd_en && adr == `STCI_OFS_ADC_R, rd_en && adr == `STCI_OFS_ADC_L};
    load     = {wr_en && adr == `STCI_OFS_DAC_R, wr_en && adr == `STCI_OFS_DAC_L};
    status   = '0;
    clr_ov   = '0;
    clr_un   = '0;
    for (int i = 0; i < 2; i++) begin
      status[i*`STCI_ST_STRIDE + `STCI_ST_ADC_RDY]  = adc_ready(q.chan[i]);
      status[i*`STCI_ST_STRIDE + `STCI_ST_OVERRUN]  = q.chan[i].overrun;
      status[i*`STCI_ST_STRIDE + `STCI_ST_DAC_RDY]  = dac_ready(q.chan[i]);
      status[i*`STCI_ST_STRIDE + `STCI_ST_UNDERRUN] = q.chan[i].underrun;
      // write one to clear the sticky error flags
      clr_ov[i] = wr_en && adr == `STCI_OFS_STATUS && wb_sel_i[0]
                  && wb_dat_i[i*`STCI_ST_STRIDE + `STCI_ST_OVERRUN];
      clr_un[i] = wr_en && adr == `STCI_OFS_STATUS && wb_sel_i[0]
                  && wb_dat_i[i*`STCI_ST_STRIDE + `STCI_ST_UNDERRUN];
    end
    status[`STCI_ST_SIDE] = q.side;

    // compare with >= so that shortening the length while the counter
    // sits above the new end wraps at once instead of running on to 255
    // phase counter and side select
    if (q.seq >= ends) begin
      d.seq  = '0;
      d.side = !q.side;
    end else begin
      d.seq  = q.seq + 8'h01;
    end

    // the codec data pin is asynchronous to this clock; two flops keep a
    // metastable first stage away from the shift registers
    // only the second stage of the synchroniser is read anywhere
    d.sync = {q.sync[0], sdout_i};

    // a reserved length code reads back as written and runs as 128
    // control register write
    if (wr_en && adr == `STCI_OFS_CTRL) begin
      d.ctrl = stci_pkg::stci_ctrl_t'(ctrl_new[5:0]);
    end

    // channels
    for (int i = 0; i < 2; i++) begin
      d.chan[i] = chan_step(q.chan[i], lane_on[i], q.seq[7:2], cap_ph, snd_ph,
                            q.sync[1], q.ctrl.en[i], fetch[i], load[i] && |wb_sel_i,
                            wb_dat_i, wb_sel_i, q.ctrl.crst[i], clr_ov[i], clr_un[i]);
    end

    // registered ack costs a cycle per access but keeps the decode off
    // the output path; the raised ack itself blocks a second take
    // bus answer: one cycle after the request, then one idle cycle
    d.ack = req;
    if (rd_en) begin
      unique case (adr)
        `STCI_OFS_CTRL:   d.rdata = ctrl_rd;
        `STCI_OFS_STATUS: d.rdata = status;
        `STCI_OFS_ADC_L:  d.rdata = {12'h000, q.chan[0].adc_sh};
        `STCI_OFS_ADC_R:  d.rdata = {12'h000, q.chan[1].adc_sh};
        `STCI_OFS_DAC_L:  d.rdata = {12'h000, q.chan[0].dac_sh};
        `STCI_OFS_DAC_R:  d.rdata = {12'h000, q.chan[1].dac_sh};
        default:          d.rdata = '0; // unmapped reads as zero
      endcase
    end

    // reset comes last so that it overrides every update above
    // synchronous reset of the whole interface
    if (rst_i) begin
      d          = '0;
      d.side     = `STCI_SIDE_LEFT;
      d.ctrl     = stci_pkg::stci_ctrl_t'(`STCI_CTRL_RESET);
      d.chan[0]  = chan_reset();
      d.chan[1]  = chan_reset();
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // the master clock is a plain copy of the system clock; the board must
  // route it as a clock, not as data
  // codec clocks straight from the system clock, the counter and the side flop; no glue logic on them
  assign mclk_o      = clk_i;
  assign sclk_o      = q.seq[1];
  assign lrck_o      = q.side;
  assign bit_idx_o   = q.seq[7:2];
  assign bit_phase_o = q.seq[1:0];

  // the inactive lane's line flop keeps its last bit; the mux hides it
  // the active side owns the serial output line
  assign sdin_o = (q.side == `STCI_SIDE_LEFT) ? q.chan[0].dac_bit
                                              : q.chan[1].dac_bit;

  // bus outputs
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;

  // ready taps combine two flops; they settle one gate after the edge
  // status taps
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      adc_rdy_o[i]  = adc_ready(q.chan[i]);
      overrun_o[i]  = q.chan[i].overrun;
      dac_rdy_o[i]  = dac_ready(q.chan[i]);
      underrun_o[i] = q.chan[i].underrun;
    end
  end

endmodule
`default_nettype wire

/* File: dv/stci_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module stci_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       sclk_o,
  input wire logic       lrck_o,
  input wire logic       sdin_o,
  input wire logic [5:0] bit_idx_o,
  input wire logic [1:0] bit_phase_o,
  input wire logic [1:0] adc_rdy_o,
  input wire logic [1:0] overrun_o,
  input wire logic [1:0] dac_rdy_o,
  input wire logic [1:0] underrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] pos;  // whole phase counter rebuilt from the taps
  assign pos = {bit_idx_o, bit_phase_o};
  // one-cycle ack pulse
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
  // counter steps by one except at the wrap
  property p_step; pos != 8'h00 |-> pos == $past(pos) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("counter skipped");
  property p_side; $changed(lrck_o) |-> pos == 8'h00; endproperty
  a_side: assert property (p_side) else $error("side flip off wrap");
  // reset must act even though the default disable is reset itself
  property p_rst; disable iff (1'b0) rst_i |=> pos == 8'h00 && !lrck_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_sclk; sclk_o == bit_phase_o[1]; endproperty
  a_sclk: assert property (p_sclk) else $error("shift clock off");
  property p_sdin; $changed(sdin_o) |-> bit_phase_o == 2'h2 || pos == 8'h00; endproperty
  a_sdin: assert property (p_sdin) else $error("line moved mid bit");
  property p_adc; $rose(adc_rdy_o[0]) |-> bit_idx_o == 6'h15 && !lrck_o; endproperty
  a_adc: assert property (p_adc) else $error("capture ready early");
  property p_ovr; $rose(overrun_o[0]) |-> bit_idx_o inside {6'h01, 6'h02}; endproperty
  a_ovr: assert property (p_ovr) else $error("overflow at wrong bit");
  property p_und; $rose(underrun_o[0]) |-> bit_idx_o == 6'h00 && !lrck_o; endproperty
  a_und: assert property (p_und) else $error("starve at wrong bit");
  property p_dac; $rose(dac_rdy_o[0]) |-> bit_idx_o inside {6'h14, 6'h15}; endproperty
  a_dac: assert property (p_dac) else $error("slot ready early");
endmodule
bind stci_top stci_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sclk_o(sclk_o), .lrck_o(lrck_o),
  .sdin_o(sdin_o), .bit_idx_o(bit_idx_o), .bit_phase_o(bit_phase_o), .adc_rdy_o(adc_rdy_o),
  .overrun_o(overrun_o), .dac_rdy_o(dac_rdy_o), .underrun_o(underrun_o));
`default_nettype wire

/* File: dv/stci_codec_model.sv */
`timescale 1ns/1ps
`default_nettype none
// codec stand-in: one fixed adc word per side, records dac words
module stci_codec_model (
  input  wire logic        mclk_i,
  input  wire logic        sclk_i,
  input  wire logic        lrck_i,
  input  wire logic        sdin_i,
  input  wire logic [19:0] tx_l_i,
  input  wire logic [19:0] tx_r_i,
  output logic             sdout_o,
  output logic [19:0]      rx_l_o,
  output logic [19:0]      rx_r_o
);
  logic        sclk_q = 1'b0;      // last seen shift clock
  logic        lrck_q = 1'b0;      // last seen side
  logic [5:0]  cnt    = 6'h00;     // bit slot within the side
  logic [19:0] sh     = 20'h00000; // gathered dac bits
  logic [19:0] tx;                 // word of the active side
  initial sdout_o = 1'b0;
  assign tx = lrck_i ? tx_r_i : tx_l_i;
  // edges are seen one mclk late; data still leads the capture phase
  always @(posedge mclk_i) begin
    sclk_q <= sclk_i;
    lrck_q <= lrck_i;
    if (lrck_i !== lrck_q) begin
      cnt <= 6'h00;
      if (lrck_q) rx_r_o <= sh;
      else rx_l_o <= sh;
      sdout_o <= ~sdout_o;  // bit zero carries no data, keep it moving
    end else if (sclk_q === 1'b1 && sclk_i === 1'b0) begin
      cnt <= cnt + 6'h01;
      if (cnt < 6'h14) sdout_o <= tx[6'h13 - cnt];  // msb first
      else sdout_o <= ~sdout_o;  // released line never holds a value
    end else if (sclk_q === 1'b0 && sclk_i === 1'b1 && cnt != 6'h00 && cnt <= 6'h14)
      sh <= {sh[18:0], sdin_i};  // take dac bit on rising clock
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stci_consts.svh"
module testbench;
  localparam logic [19:0] AL = 20'hA5C3E, AR = 20'h5A3C1, DL = 20'hC0FFE, DR = 20'h3B7D9;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic        wb_ack_o, mclk_o, sclk_o, lrck_o, sdin_o, sdout_i;
  logic [5:0]  bit_idx_o;
  logic [1:0]  bit_phase_o, adc_rdy_o, overrun_o, dac_rdy_o, underrun_o;
  logic [19:0] rx_l, rx_r;
  int          mismatches = 0, total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  stci_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mclk_o(mclk_o), .sclk_o(sclk_o),
    .lrck_o(lrck_o), .sdin_o(sdin_o), .sdout_i(sdout_i), .bit_idx_o(bit_idx_o),
    .bit_phase_o(bit_phase_o), .adc_rdy_o(adc_rdy_o), .overrun_o(overrun_o),
    .dac_rdy_o(dac_rdy_o), .underrun_o(underrun_o));
  stci_codec_model u_codec (.mclk_i(mclk_o), .sclk_i(sclk_o), .lrck_i(lrck_o), .sdin_i(sdin_o),
    .tx_l_i(AL), .tx_r_i(AR), .sdout_o(sdout_i), .rx_l_o(rx_l), .rx_r_o(rx_r));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack, one idle cycle after
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin mismatches++; print_verdict(); end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // bounded wait until the side select shows v
  task automatic wait_side(input logic v);
    int n;
    n = 0;
    while (lrck_o !== v && n < 2000) begin @(posedge clk_i); n++; end
    if (n >= 2000) begin mismatches++; print_verdict(); end
  endtask
  // host loads and fetches while the codec streams both ways
  task automatic t_loop;
    wait_side(1'b1);
    wb(1'b1, `STCI_OFS_DAC_L, {12'h0, DL}); chk(dac_rdy_o[0], 1'b1);
    wb(1'b1, `STCI_OFS_CTRL, 32'h3);
    wb(1'b1, `STCI_OFS_DAC_L, {12'h0, DL}); chk(dac_rdy_o[0], 1'b0);
    wait_side(1'b0); wb(1'b1, `STCI_OFS_DAC_R, {12'h0, DR});
    wait_side(1'b1); wb(1'b0, `STCI_OFS_ADC_L, 32'h0); chk(rdat, {12'h0, AL});
    chk(rx_l, DL);
    chk(adc_rdy_o[0], 1'b0);
    wait_side(1'b0); wb(1'b0, `STCI_OFS_ADC_R, 32'h0); chk(rdat, {12'h0, AR});
    chk(rx_r, DR);
    wait_side(1'b1); repeat (100) @(posedge clk_i);
    chk({adc_rdy_o, overrun_o, dac_rdy_o, underrun_o}, 8'hFF);
    wb(1'b1, `STCI_OFS_STATUS, 32'hAA); wb(1'b0, `STCI_OFS_STATUS, 32'h0);
    chk(rdat, 32'h155);
  endtask
  // channel reset of the right lane while the left one is active
  task automatic t_crst;
    wait_side(1'b0);
    wb(1'b1, `STCI_OFS_CTRL, 32'h23); wb(1'b0, `STCI_OFS_ADC_R, 32'h0); chk(rdat, 32'h0);
    chk({adc_rdy_o[1], overrun_o[1], dac_rdy_o[1], underrun_o[1]}, 4'h2);
    wb(1'b1, `STCI_OFS_CTRL, 32'h3);
  endtask
  // every length code, reserved one included
  task automatic t_len;
    int lens[4] = '{128, 192, 256, 128};
    int n;
    logic v;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `STCI_OFS_CTRL, (i << 2) | 3);
      v = ~lrck_o;
      wait_side(v);
      n = 0;
      do begin @(posedge clk_i); n++; end while (lrck_o === v && n < 600);
      if (n >= 600) begin mismatches++; print_verdict(); end
      chk(n, lens[i]);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    chk({lrck_o, bit_idx_o, bit_phase_o}, 9'h000);
    chk({adc_rdy_o, overrun_o, dac_rdy_o, underrun_o}, 8'h0C);
    rst_i <= 1'b0;
    // master clock looked at low and high, at the falling system clock edge and at its own rising edge
    @(negedge clk_i) chk(mclk_o, 1'b0);
    @(posedge mclk_o) chk(mclk_o, 1'b1);
    wb(1'b0, `STCI_OFS_CTRL, 32'h0); chk(rdat, 32'h0);
    wb(1'b1, 8'h20, 32'hFFFF); wb(1'b0, 8'h20, 32'h0); chk(rdat, 32'h0);
    t_loop();
    t_crst();
    t_len();
    print_verdict();
  end
endmodule
`default_nettype wire
